//--- aie_params.svh
`ifndef AIE_PARAMS_SVH
`define AIE_PARAMS_SVH

// ---------------------------------------------------------------
// Clock and io pulse timing
// ---------------------------------------------------------------
`define AIE_CLK_NS 25
`define AIE_IOP_NS 100
`define AIE_GAP_NS 100
// Least times, rounded up to whole cycles
`define AIE_IOP_CYC ((`AIE_IOP_NS + `AIE_CLK_NS - 1) / `AIE_CLK_NS)
`define AIE_GAP_CYC ((`AIE_GAP_NS + `AIE_CLK_NS - 1) / `AIE_CLK_NS)
`define AIE_SLOTS 3

// ---------------------------------------------------------------
// Instruction codes
// ---------------------------------------------------------------
`define AIE_OPC_IOT 3'h6
`define AIE_OPC_OPR 3'h7
`define AIE_CODE_ION 12'hc01
`define AIE_CODE_IOF 12'hc02

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define AIE_REG_CTRL 8'h00
`define AIE_REG_STAT 8'h04
`define AIE_REG_ACC 8'h08
`define AIE_CTRL_INTEN 0
`define AIE_STAT_PAUSE 0
`define AIE_STAT_SKIP 1
`define AIE_STAT_LINK 2
`define AIE_STAT_INTEN 3
`define AIE_STAT_SLOT 4
`define AIE_ACC_RESET 12'h000

`endif

//--- aie_pkg.sv
package aie_pkg;

   // Processor timing seen by the block, all on clk
   typedef struct packed {
      logic fetch_state;
      logic time_state_three;
      logic time_pulse_three;
   } aie_timing_type;

   // Io bus outputs toward the peripheral selectors
   typedef struct packed {
      logic [5:0] device_select;
      logic [2:0] io_pulse;
      logic io_load_strobe;
   } aie_io_type;

   typedef enum logic [1:0] {
      AIE_IDLE,
      AIE_PULSE,
      AIE_GAP
   } aie_gen_state_type;

endpackage

//--- aie_augmented_exec.sv
// How it works
// - Opcode 6 is an io transfer; bits 03-08 are the device select code.
// - Bits 09, 10, 11 each enable one io pulse; clear bits give none.
// - Io transfer and operate finish inside one fetch cycle.
// - Time pulse three sets pause and starts the pulse generator until done.
// - Every io pulse yields an io load strobe that asserts accumulator load.
// - Clear request at the strobe stops recirculation, so zeros load.
// - Peripheral data loads at strobes of the weight 2 and 4 pulses.
// - Code 6001 sets interrupt enable; 6002 clears it.
// - Opcode 7: bit 03 clear is group one; set with 11 clear is group two.
// - Operate level and buffer bits three and eleven give the group enable levels.
// - Operate changes land at time pulse three of fetch time state three.
// - Straight pass is asserted for all operates except group one rotates.
// - Several micro-operations of one instruction act in the same cycle.
// - Bits 04 and 06 clear: accumulator recirculates unchanged.
// - Bit 06 alone: accumulator is complemented.
// - Bit 04 alone: accumulator is cleared.
// - Bits 04 and 06: accumulator ends all ones.
// - Bits 05 and 07 clear: link recirculates unchanged.
// - Group two tests accumulator and link to decide a skip.
// - Bit 05 clears link, bit 07 complements; both leave it one.
// - Right rotate: link to bit zero, bit eleven to link; left reverses.
`timescale 1ns/1ps
`default_nettype none
`include "aie_params.svh"

module aie_augmented_exec (
   input wire logic clk,
   input wire logic resetn,
   input wire aie_pkg::aie_timing_type timing,
   input wire logic [2:0] instr_register,
   input wire logic [11:0] memory_buffer,
   input wire logic [11:0] io_data_in,
   input wire logic accum_zero_request,
   input wire logic skip_request,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output var aie_pkg::aie_io_type io_bus,
   output logic timing_pause,
   output logic io_cycle_done,
   output logic accum_load,
   output logic straight_pass,
   output logic operate_group_one,
   output logic operate_group_two,
   output logic [11:0] accumulator,
   output logic link_bit,
   output logic skip_flag,
   output logic interrupt_enable
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Bit k in the processor's numbering, bit 0 most significant
   function automatic logic mbit(input logic [11:0] w, input int k);
      mbit = w[11 - k];
   endfunction

   // One rotate step of link and accumulator, {link, acc}
   function automatic logic [12:0] rot1(input logic [12:0] la, input logic right);
      if (right) begin
         rot1 = {la[0], la[12], la[11:1]};
      end else begin
         rot1 = {la[11], la[10:0], la[12]};
      end
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [11:0] data_meta_r, data_sync_r;
   logic zero_meta_r, zero_sync_r;
   logic skip_meta_r, skip_sync_r;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         data_meta_r <= 12'h000;
         data_sync_r <= 12'h000;
         zero_meta_r <= 1'b0;
         zero_sync_r <= 1'b0;
         skip_meta_r <= 1'b0;
         skip_sync_r <= 1'b0;
      end else begin
         data_meta_r <= io_data_in;
         data_sync_r <= data_meta_r;
         zero_meta_r <= accum_zero_request;
         zero_sync_r <= zero_meta_r;
         skip_meta_r <= skip_request;
         skip_sync_r <= skip_meta_r;
      end
   end

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   logic tp3_fetch, is_iot, is_opr, grp1, grp2, rot_r, rot_l, rotating, opr_go;

   assign tp3_fetch = timing.time_pulse_three && timing.fetch_state
                      && timing.time_state_three;
   assign is_iot = instr_register == `AIE_OPC_IOT;
   assign is_opr = instr_register == `AIE_OPC_OPR;
   assign grp1 = is_opr && !mbit(memory_buffer, 3);
   assign grp2 = is_opr && mbit(memory_buffer, 3) && !mbit(memory_buffer, 11);
   // Both rotate bits set is a software fault; neither rotation is done then
   assign rot_r = grp1 && mbit(memory_buffer, 8) && !mbit(memory_buffer, 9);
   assign rot_l = grp1 && mbit(memory_buffer, 9) && !mbit(memory_buffer, 8);
   assign rotating = grp1 && (mbit(memory_buffer, 8) || mbit(memory_buffer, 9));
   assign opr_go = tp3_fetch && (grp1 || grp2);

   assign operate_group_one = grp1 && timing.time_state_three;
   assign operate_group_two = grp2 && timing.time_state_three;
   assign straight_pass = is_opr && timing.time_state_three && !rotating;

   // ---------------------------------------------------------------
   // Io pulse generator
   // ---------------------------------------------------------------
   aie_pkg::aie_gen_state_type gen_state_r;
   logic [1:0] slot_r;
   logic [3:0] cnt_r;
   logic [2:0] pulse_en_r;
   logic [5:0] select_r;
   logic [2:0] io_pulse_r;
   logic io_strobe_r, pause_r, done_r;
   logic [2:0] slot_onehot;

   assign slot_onehot = 3'(3'h1 << slot_r);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         gen_state_r <= aie_pkg::AIE_IDLE;
         slot_r <= 2'h0;
         cnt_r <= 4'h0;
         pulse_en_r <= 3'h0;
         select_r <= 6'h00;
         io_pulse_r <= 3'h0;
         io_strobe_r <= 1'b0;
         pause_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         io_strobe_r <= 1'b0;
         done_r <= 1'b0;
         case (gen_state_r)
            aie_pkg::AIE_IDLE: begin
               if (tp3_fetch && is_iot) begin
                  pause_r <= 1'b1;
                  // Index 0 is weight 1 (bit 11), 2 is weight 4 (bit 09)
                  pulse_en_r <= {mbit(memory_buffer, 9), mbit(memory_buffer, 10),
                                 mbit(memory_buffer, 11)};
                  select_r <= memory_buffer[8:3];
                  slot_r <= 2'h0;
                  cnt_r <= 4'h0;
                  io_pulse_r <= {2'h0, mbit(memory_buffer, 11)};
                  gen_state_r <= aie_pkg::AIE_PULSE;
               end
            end
            aie_pkg::AIE_PULSE: begin
               if (cnt_r == 4'(`AIE_IOP_CYC - 1)) begin
                  io_pulse_r <= 3'h0;
                  io_strobe_r <= |(pulse_en_r & slot_onehot);
                  cnt_r <= 4'h0;
                  gen_state_r <= aie_pkg::AIE_GAP;
               end else begin
                  cnt_r <= cnt_r + 4'h1;
               end
            end
            aie_pkg::AIE_GAP: begin
               if (cnt_r == 4'(`AIE_GAP_CYC - 1)) begin
                  cnt_r <= 4'h0;
                  if (slot_r == 2'(`AIE_SLOTS - 1)) begin
                     pause_r <= 1'b0;
                     done_r <= 1'b1;
                     gen_state_r <= aie_pkg::AIE_IDLE;
                  end else begin
                     slot_r <= slot_r + 2'h1;
                     io_pulse_r <= pulse_en_r & 3'(slot_onehot << 1);
                     gen_state_r <= aie_pkg::AIE_PULSE;
                  end
               end else begin
                  cnt_r <= cnt_r + 4'h1;
               end
            end
            default: begin
               gen_state_r <= aie_pkg::AIE_IDLE;
               pause_r <= 1'b0;
               io_pulse_r <= 3'h0;
            end
         endcase
      end
   end

   assign io_bus = '{select_r, io_pulse_r, io_strobe_r};
   assign timing_pause = pause_r;
   assign io_cycle_done = done_r;
   assign accum_load = io_strobe_r || opr_go;

   // ---------------------------------------------------------------
   // Operate data path
   // ---------------------------------------------------------------
   logic [11:0] acc_r;
   logic link_r;
   logic [11:0] g1_a0, g1_a1;
   logic g1_l0, g1_l1;
   logic [12:0] g1_rot;
   logic g2_cond, g2_skip;
   logic [11:0] io_acc;

   always_comb begin
      g1_a0 = mbit(memory_buffer, 4) ? 12'h000 : acc_r;
      g1_a1 = mbit(memory_buffer, 6) ? ~g1_a0 : g1_a0;
      g1_l0 = mbit(memory_buffer, 5) ? 1'b0 : link_r;
      g1_l1 = mbit(memory_buffer, 7) ? ~g1_l0 : g1_l0;
      g1_rot = {g1_l1, g1_a1};
      if (rot_r || rot_l) begin
         g1_rot = rot1(g1_rot, rot_r);
         if (mbit(memory_buffer, 10)) begin
            g1_rot = rot1(g1_rot, rot_r);
         end
      end
   end

   // Skip tests look at the accumulator before any group-two clear
   always_comb begin
      g2_cond = (mbit(memory_buffer, 5) && mbit(acc_r, 0))
                || (mbit(memory_buffer, 6) && acc_r == 12'h000)
                || (mbit(memory_buffer, 7) && link_r);
      g2_skip = mbit(memory_buffer, 8) ? !g2_cond : g2_cond;
   end

   // Clear request blocks recirculation; data ORs in on weights 2 and 4
   assign io_acc = (zero_sync_r ? 12'h000 : acc_r)
                   | ((slot_r != 2'h0) ? data_sync_r : 12'h000);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         acc_r <= `AIE_ACC_RESET;
         link_r <= 1'b0;
      end else if (opr_go && grp1) begin
         acc_r <= g1_rot[11:0];
         link_r <= g1_rot[12];
      end else if (opr_go) begin
         acc_r <= mbit(memory_buffer, 4) ? 12'h000 : acc_r;
      end else if (io_strobe_r) begin
         acc_r <= io_acc;
      end else if (reg_write && reg_addr == `AIE_REG_ACC) begin
         acc_r <= reg_wdata[11:0];
      end
   end

   // Skip flag: a peripheral skip at a strobe is never lost to a new fetch
   logic skip_r;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         skip_r <= 1'b0;
      end else if (io_strobe_r && skip_sync_r) begin
         skip_r <= 1'b1;
      end else if (opr_go && grp2) begin
         skip_r <= g2_skip;
      end else if (tp3_fetch) begin
         skip_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt enable
   // ---------------------------------------------------------------
   logic inten_r;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         inten_r <= 1'b0;
      end else if (tp3_fetch && memory_buffer == `AIE_CODE_ION && is_iot) begin
         inten_r <= 1'b1;
      end else if (tp3_fetch && memory_buffer == `AIE_CODE_IOF && is_iot) begin
         inten_r <= 1'b0;
      end else if (reg_write && reg_addr == `AIE_REG_CTRL) begin
         inten_r <= reg_wdata[`AIE_CTRL_INTEN];
      end
   end

   assign accumulator = acc_r;
   assign link_bit = link_r;
   assign skip_flag = skip_r;
   assign interrupt_enable = inten_r;

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         reg_rdata <= 32'h0000_0000;
         case (reg_addr)
            `AIE_REG_CTRL: begin
               reg_rdata[`AIE_CTRL_INTEN] <= inten_r;
            end
            `AIE_REG_STAT: begin
               reg_rdata[`AIE_STAT_PAUSE] <= pause_r;
               reg_rdata[`AIE_STAT_SKIP] <= skip_r;
               reg_rdata[`AIE_STAT_LINK] <= link_r;
               reg_rdata[`AIE_STAT_INTEN] <= inten_r;
               reg_rdata[`AIE_STAT_SLOT +: 2] <= slot_r;
            end
            `AIE_REG_ACC: begin
               reg_rdata[11:0] <= acc_r;
            end
            default: begin
               reg_rdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_iot_pause;
      @(posedge clk) disable iff (!resetn)
      (tp3_fetch && is_iot && gen_state_r == aie_pkg::AIE_IDLE)
         |=> pause_r [*8];
   endproperty
   a_iot_pause: assert property (p_iot_pause) else $error("pause not held");
   property p_pulse_enabled;
      @(posedge clk) disable iff (!resetn)
      (io_pulse_r != 3'h0) |-> ((io_pulse_r & ~pulse_en_r) == 3'h0) && pause_r;
   endproperty
   a_pulse_enabled: assert property (p_pulse_enabled) else $error("stray io pulse");
   property p_strobe_load;
      @(posedge clk) disable iff (!resetn)
      $fell(|io_pulse_r) |-> io_strobe_r && accum_load;
   endproperty
   a_strobe_load: assert property (p_strobe_load) else $error("no strobe after pulse");
   property p_zero_load;
      @(posedge clk) disable iff (!resetn)
      (io_strobe_r && zero_sync_r && slot_r == 2'h0) |=> acc_r == 12'h000;
   endproperty
   a_zero_load: assert property (p_zero_load) else $error("clear request ignored");
   property p_data_load;
      @(posedge clk) disable iff (!resetn)
      (io_strobe_r && !zero_sync_r && slot_r == 2'h1)
         |=> acc_r == ($past(acc_r) | $past(data_sync_r));
   endproperty
   a_data_load: assert property (p_data_load) else $error("data not loaded");
   property p_ion_iof;
      @(posedge clk) disable iff (!resetn)
      (tp3_fetch && is_iot && (memory_buffer == `AIE_CODE_ION
         || memory_buffer == `AIE_CODE_IOF))
         |=> inten_r == $past(memory_buffer[0]);
   endproperty
   a_ion_iof: assert property (p_ion_iof) else $error("interrupt enable wrong");
   property p_cla_cma;
      @(posedge clk) disable iff (!resetn)
      (opr_go && memory_buffer == 12'hea0) |=> acc_r == 12'hfff;
   endproperty
   a_cla_cma: assert property (p_cla_cma) else $error("accumulator not all ones");
   property p_cma;
      @(posedge clk) disable iff (!resetn)
      (opr_go && memory_buffer == 12'he20) |=> acc_r == ~$past(acc_r);
   endproperty
   a_cma: assert property (p_cma) else $error("accumulator not complemented");
   property p_nop;
      @(posedge clk) disable iff (!resetn)
      (opr_go && memory_buffer == 12'he00) |=> $stable(acc_r) && $stable(link_r);
   endproperty
   a_nop: assert property (p_nop) else $error("idle operate changed state");
   property p_set_link;
      @(posedge clk) disable iff (!resetn)
      (opr_go && memory_buffer == 12'he50) |=> link_r;
   endproperty
   a_set_link: assert property (p_set_link) else $error("link not set");
   property p_rotate_right;
      @(posedge clk) disable iff (!resetn)
      (opr_go && memory_buffer == 12'he08)
         |=> acc_r == {$past(link_r), $past(acc_r[11:1])} && link_r == $past(acc_r[0]);
   endproperty
   a_rotate_right: assert property (p_rotate_right) else $error("bad right rotate");
   property p_straight;
      @(posedge clk) disable iff (!resetn)
      (opr_go && !rotating) |-> straight_pass && accum_load;
   endproperty
   a_straight: assert property (p_straight) else $error("straight pass missing");
   property p_skip_always;
      @(posedge clk) disable iff (!resetn)
      (opr_go && memory_buffer == 12'hf08) |=> skip_r;
   endproperty
   a_skip_always: assert property (p_skip_always) else $error("skip not taken");

endmodule

`default_nettype wire

//--- aie_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

module aie_periph_model #(
   parameter logic [5:0] SEL_CODE = 6'h15
) (
   input wire logic clk,
   input wire logic resetn,
   input wire aie_pkg::aie_io_type io_bus,
   input wire logic [11:0] data_word,
   input wire logic [2:0] data_slots,
   input wire logic [2:0] clear_slots,
   input wire logic [2:0] skip_slots,
   output logic [2:0] device_cmd,
   output logic [11:0] io_data_in,
   output logic accum_zero_request,
   output logic skip_request
);
   // ------------------------------------------------------------
   // Device selector
   // ------------------------------------------------------------
   logic selected;
   logic [2:0] live;
   logic [1:0] hold_r [3];

   assign selected = (io_bus.device_select == SEL_CODE);
   assign device_cmd = selected ? io_bus.io_pulse : 3'h0;

   // Hold outlasts the pulse so the processor's synchronisers still see it at the strobe
   always_ff @(posedge clk) begin
      for (int k = 0; k < 3; k++) begin
         if (!resetn) begin
            hold_r[k] <= 2'h0;
         end else if (io_bus.io_pulse[k]) begin
            hold_r[k] <= 2'h3;
         end else if (hold_r[k] != 2'h0) begin
            hold_r[k] <= hold_r[k] - 2'h1;
         end
      end
   end

   always_comb begin
      for (int k = 0; k < 3; k++) begin
         live[k] = selected & (io_bus.io_pulse[k] | (hold_r[k] != 2'h0));
      end
   end

   // Bus lines are pulled to the inactive level when no device drives them
   assign io_data_in = |(live & data_slots) ? data_word : 12'h000;
   assign accum_zero_request = |(live & clear_slots);
   assign skip_request = |(live & skip_slots);
endmodule

`default_nettype wire

//--- aie_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   localparam logic [5:0] SEL_CODE = 6'h15;
   localparam logic [11:0] OPS [20] = '{12'he00, 12'he20, 12'he80, 12'hea0, 12'he10, 12'he40,
      12'he50, 12'he08, 12'he04, 12'he0a, 12'he06, 12'he30, 12'he0c, 12'hf20, 12'hf40,
      12'hf10, 12'hf08, 12'hfa0, 12'hf38, 12'hf01};
   logic clk = 1'b0;
   logic resetn = 1'b0;
   aie_pkg::aie_timing_type timing = '0;
   logic [2:0] instr_register = 3'h0;
   logic [11:0] memory_buffer = 12'h000;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [11:0] data_word = 12'h000;
   logic [2:0] data_slots = 3'h0;
   logic [2:0] clear_slots = 3'h0;
   logic [2:0] skip_slots = 3'h0;
   logic [31:0] reg_rdata;
   aie_pkg::aie_io_type io_bus;
   logic timing_pause, io_cycle_done, accum_load, straight_pass, operate_group_one;
   logic operate_group_two, link_bit, skip_flag, interrupt_enable, accum_zero_request;
   logic skip_request, ld_s, sp_s, g1_s, g2_s;
   logic [11:0] accumulator, io_data_in;
   logic [2:0] device_cmd, pulse_seen, cmd_seen;
   logic [12:0] st_m;
   int miscompares = 0;
   int check_count = 0;
   int strobe_cnt = 0;

   always #12.5 clk = ~clk;

   aie_augmented_exec u_dut (.clk(clk), .resetn(resetn), .timing(timing),
      .instr_register(instr_register), .memory_buffer(memory_buffer), .io_data_in(io_data_in),
      .accum_zero_request(accum_zero_request), .skip_request(skip_request),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .io_bus(io_bus), .timing_pause(timing_pause),
      .io_cycle_done(io_cycle_done), .accum_load(accum_load), .straight_pass(straight_pass),
      .operate_group_one(operate_group_one), .operate_group_two(operate_group_two),
      .accumulator(accumulator), .link_bit(link_bit), .skip_flag(skip_flag),
      .interrupt_enable(interrupt_enable));

   aie_periph_model #(.SEL_CODE(SEL_CODE)) u_periph (.clk(clk), .resetn(resetn),
      .io_bus(io_bus), .data_word(data_word), .data_slots(data_slots),
      .clear_slots(clear_slots), .skip_slots(skip_slots), .device_cmd(device_cmd),
      .io_data_in(io_data_in), .accum_zero_request(accum_zero_request),
      .skip_request(skip_request));

   always @(posedge clk) begin
      pulse_seen <= pulse_seen | io_bus.io_pulse;
      cmd_seen <= cmd_seen | device_cmd;
      strobe_cnt <= strobe_cnt + int'(io_bus.io_load_strobe & accum_load);
   end

   // ------------------------------------------------------------
   // Tasks and expectations
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      // Step off the edge so callers see settled outputs and clear counters race-free
      #1;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // One fetch time pulse three; combinational outputs sampled inside it
   task automatic fire(input logic [2:0] opc, input logic [11:0] mb);
      @(posedge clk);
      timing <= 3'b111;
      instr_register <= opc;
      memory_buffer <= mb;
      #1;
      {ld_s, sp_s, g1_s, g2_s} = {accum_load, straight_pass, operate_group_one, operate_group_two};
      @(posedge clk);
      timing <= 3'b000;
      #1;
   endtask

   function automatic logic [12:0] exp_op(input logic [12:0] v, input logic [11:0] mb);
      logic [12:0] r;
      r = v;
      if (!mb[8]) begin
         r[11:0] = mb[7] ? 12'h000 : r[11:0];
         r[11:0] = mb[5] ? ~r[11:0] : r[11:0];
         r[12] = (mb[6] ? 1'b0 : r[12]) ^ mb[4];
         for (int i = 0; i < (mb[1] ? 2 : 1); i++) begin
            if (mb[3] && !mb[2]) r = {r[0], r[12:1]};
            if (mb[2] && !mb[3]) r = {r[11:0], r[12]};
         end
      end else if (!mb[0] && mb[7]) begin
         r[11:0] = 12'h000;
      end
      return r;
   endfunction

   function automatic logic exp_skip(input logic [12:0] v, input logic [11:0] mb);
      logic c;
      c = (mb[6] & v[11]) | (mb[5] & (v[11:0] == 12'h000)) | (mb[4] & v[12]);
      return mb[8] & ~mb[0] & (mb[3] ^ c);
   endfunction

   function automatic logic [11:0] exp_io(input logic [11:0] a, input logic [11:0] mb,
      input logic sel);
      for (int k = 0; k < 3; k++) begin
         if (mb[k] && sel) begin
            a = clear_slots[k] ? 12'h000 : a;
            a = (k > 0 && data_slots[k]) ? (a | data_word) : a;
         end
      end
      return a;
   endfunction

   task automatic run_io(input logic [11:0] mb, input logic sel);
      int n;
      pulse_seen = 3'h0;
      cmd_seen = 3'h0;
      strobe_cnt = 0;
      fire(3'h6, mb);
      check("pause", timing_pause, 1);
      check("select", io_bus.device_select, mb[8:3]);
      n = 0;
      while (io_cycle_done !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("io length", n, 24);
      check("pause end", timing_pause, 0);
      check("pulses", pulse_seen, mb[2:0]);
      check("dev cmd", cmd_seen, sel ? mb[2:0] : 3'h0);
      check("strobes", strobe_cnt, $countones(mb[2:0]));
      st_m[11:0] = exp_io(st_m[11:0], mb, sel);
      check("io acc", accumulator, st_m[11:0]);
      check("io skip", skip_flag, sel & |(skip_slots & mb[2:0]));
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [31:0] r;
      logic [11:0] mb;
      logic sel;
      r = $urandom(32'h7f1f);
      st_m = 13'h0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      #1;
      check("acc rst", {link_bit, accumulator, interrupt_enable, timing_pause}, 0);
      for (int a = 0; a < 16; a += 4) begin
         reg_rd(8'(a), d);
         check("reg rst", d, 0);
      end
      r = $urandom;
      reg_wr(8'h08, r);
      reg_wr(8'h0c, r);
      reg_rd(8'h08, d);
      check("acc rw", d, {20'h0, r[11:0]});
      reg_rd(8'h0c, d);
      check("unmapped", d, 0);
      reg_wr(8'h00, 32'h1);
      check("ie reg", interrupt_enable, 1);
      $display("Test registers done");
      st_m[11:0] = r[11:0];
      run_io(12'hc02, 1'b0);
      check("ie off", interrupt_enable, 0);
      run_io(12'hc01, 1'b0);
      check("ie on", interrupt_enable, 1);
      for (int i = 0; i < 14; i++) begin
         r = $urandom;
         sel = (i < 2) | r[0];
         mb = {3'h6, sel ? SEL_CODE : (r[6:1] == SEL_CODE ? ~SEL_CODE : r[6:1]), r[9:7]};
         mb[2:0] = (i < 2) ? 3'h7 : mb[2:0];
         @(posedge clk);
         data_slots <= (i < 2) ? 3'h7 : r[12:10];
         clear_slots <= (i == 0) ? 3'h1 : ((i == 1) ? 3'h2 : r[15:13]);
         skip_slots <= r[18:16];
         data_word <= r[30:19];
         reg_wr(8'h08, {20'h0, r[31:20]});
         st_m[11:0] = r[31:20];
         run_io(mb, sel);
      end
      $display("Test io transfer done");
      for (int i = 0; i < 44; i++) begin
         r = $urandom;
         mb = (i < 20) ? OPS[i] : {3'h7, r[8:1], 1'b0};
         if (i >= 20 && !mb[8] && mb[3]) mb[2] = 1'b0;
         if (i >= 20 && mb[8]) mb[2:1] = 2'h0;
         reg_wr(8'h08, (i % 3 == 0) ? 32'h0 : {20'h0, r[31:20]});
         st_m[11:0] = (i % 3 == 0) ? 12'h000 : r[31:20];
         fire(3'h7, mb);
         check("group one", g1_s, !mb[8]);
         check("group two", g2_s, mb[8] & !mb[0]);
         check("load", ld_s, !mb[8] | !mb[0]);
         if (mb[8] || !(mb[3] && mb[2])) check("pass", sp_s, mb[8] | !(mb[3] | mb[2]));
         if (mb != 12'hf01) check("skip", skip_flag, exp_skip(st_m, mb));
         st_m = exp_op(st_m, mb);
         check("op state", {link_bit, accumulator}, st_m);
         check("op state", {link_bit, accumulator}, st_m);
      end
      $display("Test operate done");
      tally_and_finish();
   end

   initial begin
      #500000;
      miscompares++;
      tally_and_finish();
   end
endmodule

`default_nettype wire
